// ==== hw/hfs_map.vh ====
// Constants for the HDLC frame status block: register offsets, bit fields,
// mode codes, thresholds and timing. Definitions only, no logic.
// Behaviour
// - Writing more than 32 bytes into the transmit buffer raises the transmit overflow flag.
// - The transmit overflow flag clears on a transmitter reset command or when the accessible half has fully moved on.
// - The transmit write-enable status bit is high whenever the host may write more data.
// - Command-in-progress is high while a command executes; the host writes no command meanwhile.
// - The freeze signaling status bit reads 0 when freezing is inactive and 1 when active.
// - At end of frame the frame status byte is stored in the receive buffer as the last byte.
// - A frame whose bit length is not a multiple of 8 is marked invalid, otherwise valid unless too short.
// - In 16-bit address mode 011 a 4 byte frame (3 to 4 with check on) is too short.
// - In 8-bit address mode 010 a 3 byte frame (2 to 3 with check on) is too short.
// - Frames below the too-short thresholds are dropped silently, data and status alike.
// - The status byte overflow bit is set if the receive buffer overflowed during the frame.
// - The receive overflow interrupt status rises as soon as any overflow occurs.
// - The check result bit is 1 when the frame check passes and 0 when it fails.
// - The aborted bit is set when the sender aborted the frame; its status byte is still stored like any other.
`ifndef HFS_MAP_VH
`define HFS_MAP_VH

`define HFS_ADDR_W        8
`define HFS_OFF_SIGSTAT   8'h64
`define HFS_OFF_COMMAND   8'h70
`define HFS_OFF_MODE      8'h71
`define HFS_OFF_IRQ_STAT  8'h72
`define HFS_OFF_IRQ_MASK  8'h73
`define HFS_OFF_RX_STAT   8'h74

// Signaling status fields
`define HFS_SS_TXOVF      7
`define HFS_SS_TXWEN      6
`define HFS_SS_REP        5
`define HFS_SS_IDLE       3
`define HFS_SS_CIP        2
`define HFS_SS_FREEZE     1

// Command register fields
`define HFS_CMD_TXRES     0
`define HFS_CMD_REP       1

// Mode register fields
`define HFS_MODE_LSB      0
`define HFS_MODE_MSB      2
`define HFS_MODE_CHK      3
`define HFS_MDS_ADDR16    3'h3
`define HFS_MDS_ADDR8     3'h2

// Frame status byte fields
`define HFS_FS_VALID      7
`define HFS_FS_OVF        6
`define HFS_FS_CHK        5
`define HFS_FS_ABORT      4

// Interrupt status/mask fields
`define HFS_IRQ_OVF       0
`define HFS_IRQ_END       1

// Thresholds (bytes) and sizes
`define HFS_TX_HALF       32
`define HFS_MIN16_OFF     4
`define HFS_MIN16_ON      4
`define HFS_MIN8_OFF      3
`define HFS_MIN8_ON       3
`define HFS_LOW16_ON      3
`define HFS_LOW8_ON       2

// Command busy window: 2.5 data periods, rounded down to whole clock
// cycles so the limit is never exceeded; the data period is an assumption
`define HFS_DATA_PERIOD_NS 488
`define HFS_CLK_NS        25
`define HFS_CIP_CYCLES    ((`HFS_DATA_PERIOD_NS * 5) / (2 * `HFS_CLK_NS))

`endif

// ==== hw/hfs_sync2.v ====
// Two-stage synchroniser for one level arriving from outside the clock.
// Assumes the source is slow against the 40 MHz clock.
`timescale 1ns/10ps
`default_nettype none
module hfs_sync2 (
  input  wire clock,
  input  wire rst,
  input  wire din,
  output reg  dout
);
  reg stage1;

  always @(posedge clock) begin
    if (rst) begin
      stage1 <= 1'b0;
      dout   <= 1'b0;
    end else begin
      stage1 <= din;
      dout   <= stage1;
    end
  end
endmodule // hfs_sync2
`default_nettype wire

// ==== hw/hfs_frame_status.v ====
// HDLC frame status logic: signaling status register, command tracking,
// per-frame status byte appended to the receive buffer, interrupts.
// Assumes one 40 MHz clock, a plain register port, and that the receiver
// core and the transmit buffer logic report events as one-cycle pulses.
//
// Chosen here: the address-and-strobe port.
`timescale 1ns/10ps
`default_nettype none
`include "hfs_map.vh"
module hfs_frame_status #(
  parameter CNT_W   = 12,
  parameter CIP_CYC = `HFS_CIP_CYCLES
) (
  input  wire                   clock,
  input  wire                   rst,
  // Register port
  input  wire [`HFS_ADDR_W-1:0] addr,
  input  wire [7:0]             wdata,
  input  wire                   wr,
  input  wire                   rd,
  output reg  [7:0]             rdata,
  output reg                    irq,
  // Transmit buffer events
  input  wire                   tx_byte_written,
  input  wire                   tx_half_moved,
  output reg                    transmitter_reset_cmd,
  // Freeze signaling pin
  input  wire                   freeze_in,
  // Receiver core events
  input  wire                   rx_flag_seen,
  input  wire                   rx_frame_active,
  input  wire                   rx_byte_strobe,
  input  wire                   rx_end,
  input  wire [2:0]             rx_tail_bits,
  input  wire                   rx_check_pass,
  input  wire                   rx_abort,
  input  wire                   rx_buf_full,
  // Stream into the receive buffer
  output reg  [7:0]             rx_buffer_data,
  output reg                    rx_buffer_push,
  output reg                    rx_buffer_drop
);

  ////////////////////////////////////////////////////////////////////////
  // Pin synchronisation

  wire freeze_sync;

  hfs_sync2 u_freeze_sync (
    .clock (clock),
    .rst   (rst),
    .din   (freeze_in),
    .dout  (freeze_sync)
  );

  ////////////////////////////////////////////////////////////////////////
  // Register state

  reg [2:0]       address_mode_select;
  reg             rx_check_on;
  reg             repeat_transmission;
  reg             tx_overflow_flag;
  reg [5:0]       tx_count;
  reg             command_in_progress;
  reg [7:0]       cip_count;
  reg             rx_line_idle;
  reg [7:0]       rx_frame_status_byte;
  reg [1:0]       interrupt_status_one;
  reg [1:0]       interrupt_mask_one;
  reg [CNT_W-1:0] rx_len;
  reg             frame_ovf;

  wire wr_cmd  = wr && (addr == `HFS_OFF_COMMAND);
  wire wr_mode = wr && (addr == `HFS_OFF_MODE);
  wire wr_mask = wr && (addr == `HFS_OFF_IRQ_MASK);
  wire rd_irq  = rd && (addr == `HFS_OFF_IRQ_STAT);
  wire tx_res  = wr_cmd && wdata[`HFS_CMD_TXRES];

  wire tx_write_enable_flag = (tx_count < `HFS_TX_HALF);

  ////////////////////////////////////////////////////////////////////////
  // Transmit side and commands

  always @(posedge clock) begin
    if (rst) begin
      address_mode_select   <= 3'h0;
      rx_check_on           <= 1'b0;
      repeat_transmission   <= 1'b0;
      transmitter_reset_cmd <= 1'b0;
    end else begin
      transmitter_reset_cmd <= tx_res;
      if (wr_mode) begin
        address_mode_select <= wdata[`HFS_MODE_MSB:`HFS_MODE_LSB];
        rx_check_on         <= wdata[`HFS_MODE_CHK];
      end
      if (wr_cmd)
        repeat_transmission <= wdata[`HFS_CMD_REP];
    end
  end

  // Counts bytes in the accessible half; counter saturates so an overrun
  // burst cannot wrap back below the threshold.
  always @(posedge clock) begin
    if (rst) begin
      tx_count         <= 6'h00;
      tx_overflow_flag <= 1'b0;
    end else if (tx_res || tx_half_moved) begin
      tx_count         <= 6'h00;
      tx_overflow_flag <= 1'b0;
    end else if (tx_byte_written) begin
      if (!tx_write_enable_flag)
        tx_overflow_flag <= 1'b1;
      else
        tx_count <= tx_count + 6'h01;
    end
  end

  // Busy window after any command write; the host must wait on it.
  always @(posedge clock) begin
    if (rst) begin
      command_in_progress <= 1'b0;
      cip_count           <= 8'h00;
    end else if (wr_cmd) begin
      command_in_progress <= 1'b1;
      cip_count           <= CIP_CYC[7:0];
    end else if (cip_count > 8'h01) begin
      cip_count <= cip_count - 8'h01;
    end else begin
      cip_count           <= 8'h00;
      command_in_progress <= 1'b0;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Receive line activity

  always @(posedge clock) begin
    if (rst)
      rx_line_idle <= 1'b1;
    else
      rx_line_idle <= !(rx_flag_seen || rx_frame_active);
  end

  ////////////////////////////////////////////////////////////////////////
  // Frame status byte

  // Thresholds held at the counter width, so compares and loads keep
  // their size on purpose
  localparam [CNT_W-1:0] MIN16_OFF = `HFS_MIN16_OFF;
  localparam [CNT_W-1:0] MIN16_ON  = `HFS_MIN16_ON;
  localparam [CNT_W-1:0] LOW16_ON  = `HFS_LOW16_ON;
  localparam [CNT_W-1:0] MIN8_OFF  = `HFS_MIN8_OFF;
  localparam [CNT_W-1:0] MIN8_ON   = `HFS_MIN8_ON;
  localparam [CNT_W-1:0] LOW8_ON   = `HFS_LOW8_ON;

  reg [CNT_W-1:0] min_len;
  reg [CNT_W-1:0] low_len;
  reg             too_short;
  reg             length_bad;
  reg             discard;
  reg [7:0]       next_status;

  always @* begin
    min_len = MIN8_OFF;
    low_len = MIN8_OFF;
    case (address_mode_select)
      `HFS_MDS_ADDR16: begin
        min_len = rx_check_on ? MIN16_ON : MIN16_OFF;
        low_len = rx_check_on ? LOW16_ON : MIN16_OFF;
      end
      `HFS_MDS_ADDR8: begin
        min_len = rx_check_on ? MIN8_ON : MIN8_OFF;
        low_len = rx_check_on ? LOW8_ON : MIN8_OFF;
      end
      default: begin
        // Other modes fall back to the 8-bit address check-off thresholds, whatever the check setting
        min_len = MIN8_OFF;
        low_len = MIN8_OFF;
      end
    endcase
    too_short  = (rx_len >= low_len) && (rx_len <= min_len);
    discard    = rx_len < low_len;
    length_bad = (rx_tail_bits != 3'h0);
    next_status = 8'h00;
    next_status[`HFS_FS_VALID] = !(length_bad || too_short);
    next_status[`HFS_FS_OVF]   = frame_ovf || rx_buf_full;
    next_status[`HFS_FS_CHK]   = rx_check_pass;
    next_status[`HFS_FS_ABORT] = rx_abort;
  end

  // Overflow: a byte arriving while the buffer is full is lost.
  wire ovf_evt = rx_byte_strobe && rx_buf_full;

  always @(posedge clock) begin
    if (rst) begin
      rx_len               <= {CNT_W{1'b0}};
      frame_ovf            <= 1'b0;
      rx_frame_status_byte <= 8'h00;
      rx_buffer_data       <= 8'h00;
      rx_buffer_push       <= 1'b0;
      rx_buffer_drop       <= 1'b0;
    end else begin
      rx_buffer_push <= 1'b0;
      rx_buffer_drop <= 1'b0;
      if (rx_end) begin
        rx_len    <= {CNT_W{1'b0}};
        frame_ovf <= 1'b0;
        if (discard) begin
          rx_buffer_drop <= 1'b1;
        end else begin
          rx_frame_status_byte <= next_status;
          rx_buffer_data       <= next_status;
          rx_buffer_push       <= !rx_buf_full;
        end
      end else if (rx_byte_strobe) begin
        if (rx_len != {CNT_W{1'b1}})
          rx_len <= rx_len + {{(CNT_W-1){1'b0}}, 1'b1};
        if (rx_buf_full)
          frame_ovf <= 1'b1;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Interrupts: sticky status, cleared by reading, set wins over clear

  wire [1:0] irq_set;
  assign irq_set[`HFS_IRQ_OVF] = ovf_evt;
  assign irq_set[`HFS_IRQ_END] = rx_end && !discard;

  always @(posedge clock) begin
    if (rst) begin
      interrupt_status_one <= 2'h0;
      interrupt_mask_one   <= 2'h0;
      irq                  <= 1'b0;
    end else begin
      interrupt_status_one <= (rd_irq ? 2'h0 : interrupt_status_one)
                              | irq_set;
      if (wr_mask)
        interrupt_mask_one <= wdata[1:0];
      irq <= |(((rd_irq ? 2'h0 : interrupt_status_one) | irq_set)
               & ~(wr_mask ? wdata[1:0] : interrupt_mask_one));
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Register read

  reg [7:0] sigstat;

  always @* begin
    sigstat = 8'h00;
    sigstat[`HFS_SS_TXOVF]  = tx_overflow_flag;
    sigstat[`HFS_SS_TXWEN]  = tx_write_enable_flag;
    sigstat[`HFS_SS_REP]    = repeat_transmission;
    sigstat[`HFS_SS_IDLE]   = rx_line_idle;
    sigstat[`HFS_SS_CIP]    = command_in_progress;
    sigstat[`HFS_SS_FREEZE] = freeze_sync;
  end

  always @(posedge clock) begin
    if (rst) begin
      rdata <= 8'h00;
    end else if (rd) begin
      case (addr)
        `HFS_OFF_SIGSTAT:  rdata <= sigstat;
        `HFS_OFF_MODE:     rdata <= {4'h0, rx_check_on, address_mode_select};
        `HFS_OFF_IRQ_STAT: rdata <= {6'h00, interrupt_status_one};
        `HFS_OFF_IRQ_MASK: rdata <= {6'h00, interrupt_mask_one};
        `HFS_OFF_RX_STAT:  rdata <= rx_frame_status_byte;
        default:           rdata <= 8'h00;
      endcase
    end else begin
      rdata <= 8'h00;
    end
  end

endmodule // hfs_frame_status
`default_nettype wire

// ==== verification/hfs_frame_status_checker.sv ====
// Checker for the HDLC frame status block, bound to its top module.
// Assumes one clock and the synchronous active-high reset.
`timescale 1ns/10ps
`default_nettype none
`include "hfs_map.vh"
module hfs_frame_status_checker (
  input wire logic                   clock,
  input wire logic                   rst,
  input wire logic [`HFS_ADDR_W-1:0] addr,
  input wire logic [7:0]             wdata,
  input wire logic                   wr,
  input wire logic                   irq,
  input wire logic                   transmitter_reset_cmd,
  input wire logic                   rx_end,
  input wire logic [2:0]             rx_tail_bits,
  input wire logic                   rx_check_pass,
  input wire logic                   rx_abort,
  input wire logic                   rx_buf_full,
  input wire logic [7:0]             rx_buffer_data,
  input wire logic                   rx_buffer_push,
  input wire logic                   rx_buffer_drop
);
  logic cmd_res;
  assign cmd_res = wr && addr == `HFS_OFF_COMMAND && wdata[`HFS_CMD_TXRES];
  default clocking cb @(posedge clock); endclocking
  default disable iff (rst);
  ////////////////////////////////////////////////////////////////////////////
  a_end_answer: assert property (
    rx_end && !rx_buf_full |=> rx_buffer_push || rx_buffer_drop)
    else $error("frame end got no answer");
  a_push_cause: assert property (
    rx_buffer_push |-> $past(rx_end))
    else $error("push without frame end");
  a_push_drop: assert property (
    !(rx_buffer_push && rx_buffer_drop))
    else $error("push and drop together");
  a_tail_invalid: assert property (
    rx_end && rx_tail_bits != 3'h0 |=> !rx_buffer_push || !rx_buffer_data[7])
    else $error("odd length frame marked valid");
  a_check_bit: assert property (
    rx_end |=> !rx_buffer_push || rx_buffer_data[5] == $past(rx_check_pass))
    else $error("check result bit wrong");
  a_abort_bit: assert property (
    rx_end && rx_abort |=> !rx_buffer_push || rx_buffer_data[4])
    else $error("aborted bit missing");
  a_txres_pulse: assert property (
    cmd_res |=> transmitter_reset_cmd)
    else $error("transmitter reset not issued");
  a_txres_cause: assert property (
    transmitter_reset_cmd |-> $past(cmd_res))
    else $error("transmitter reset without command");
  a_mask_irq: assert property (
    wr && addr == `HFS_OFF_IRQ_MASK && wdata[1:0] == 2'b11 |-> ##2 !irq)
    else $error("masked interrupt still raised");
endmodule // hfs_frame_status_checker
bind hfs_frame_status hfs_frame_status_checker chk_inst (
  .clock(clock), .rst(rst), .addr(addr), .wdata(wdata), .wr(wr), .irq(irq),
  .transmitter_reset_cmd(transmitter_reset_cmd), .rx_end(rx_end),
  .rx_tail_bits(rx_tail_bits), .rx_check_pass(rx_check_pass),
  .rx_abort(rx_abort), .rx_buf_full(rx_buf_full),
  .rx_buffer_data(rx_buffer_data), .rx_buffer_push(rx_buffer_push),
  .rx_buffer_drop(rx_buffer_drop));
`default_nettype wire

// ==== verification/hfs_far_model.sv ====
// Far-side model: receiver core facing the remote station, and buffer level.
// Driven through tasks from the bench; every change lands after an edge.
`timescale 1ns/10ps
`default_nettype none
module hfs_far_model (
  input  wire logic       clock,
  output var  logic       flag,
  output var  logic       act,
  output var  logic       bst,
  output var  logic       rend,
  output var  logic       full,
  output wire logic [2:0] tail,
  output wire logic       pass,
  output wire logic       abt
);
  logic [3:0] junk = 4'h0;
  logic       hold = 1'b0;
  logic [2:0] tq   = 3'h0;
  logic       pq   = 1'b0;
  logic       aq   = 1'b0;
  // End qualifiers carry noise outside the end strobe, never stale values
  always @(posedge clock) junk <= junk + 4'h5;
  assign tail = hold ? tq : junk[2:0];
  assign pass = hold ? pq : junk[3];
  assign abt  = hold ? aq : ~junk[3];
  initial begin
    flag = 1'b0;
    act  = 1'b0;
    bst  = 1'b0;
    rend = 1'b0;
    full = 1'b0;
  end
  task automatic set_flag(input logic v);
    @(posedge clock) flag <= v;
  endtask
  task automatic send(input int n, input logic [2:0] t, input logic p,
                      input logic a, input logic ovf);
    int i;
    @(posedge clock) act <= 1'b1;
    flag <= 1'b1;
    for (i = 0; i < n; i++) begin
      @(posedge clock) bst <= 1'b1;
      full <= ovf && i == 1;
      @(posedge clock) bst <= 1'b0;
    end
    @(posedge clock) full <= 1'b0;
    rend <= 1'b1;
    hold <= 1'b1;
    tq   <= t;
    pq   <= p;
    aq   <= a;
    @(posedge clock) rend <= 1'b0;
    hold <= 1'b0;
    act  <= 1'b0;
    flag <= 1'b0;
  endtask
endmodule // hfs_far_model
`default_nettype wire

// ==== verification/hfs_frame_status_tb_top.sv ====
// Self-checking bench for the HDLC frame status block.
// Assumes the far-side model and the bound checker are compiled alongside.
`timescale 1ns/10ps
`default_nettype none
module hfs_frame_status_tb_top;
  localparam int CIP = 24;
  logic       clock = 1'b0;
  logic       rst   = 1'b1;
  logic [7:0] addr  = 8'h00;
  logic [7:0] wdata = 8'h00;
  logic       wr    = 1'b0;
  logic       rd    = 1'b0;
  logic       tbw   = 1'b0;
  logic       thm   = 1'b0;
  logic       frz   = 1'b0;
  logic [7:0] rdata, bdata, data;
  logic       irq, txres, flag, act, bst, rend, pass, abt, full, push, drop;
  logic [2:0] tail;
  int         num_errors = 0;
  int         cmp_count  = 0;
  int         cycles     = 0;
  initial forever #12.5 clock = ~clock;
  hfs_frame_status #(.CIP_CYC(CIP)) hfs_frame_status_inst (
    .clock(clock), .rst(rst), .addr(addr), .wdata(wdata), .wr(wr), .rd(rd),
    .rdata(rdata), .irq(irq), .tx_byte_written(tbw), .tx_half_moved(thm),
    .transmitter_reset_cmd(txres), .freeze_in(frz), .rx_flag_seen(flag),
    .rx_frame_active(act), .rx_byte_strobe(bst), .rx_end(rend),
    .rx_tail_bits(tail), .rx_check_pass(pass), .rx_abort(abt),
    .rx_buf_full(full), .rx_buffer_data(bdata), .rx_buffer_push(push),
    .rx_buffer_drop(drop));
  hfs_far_model hfs_far_model_inst (
    .clock(clock), .flag(flag), .act(act), .bst(bst), .rend(rend),
    .full(full), .tail(tail), .pass(pass), .abt(abt));
  ////////////////////////////////////////////////////////////////////////////
  task automatic check(input string nm, input logic [7:0] seen, exp);
    cmp_count++;
    if (seen !== exp) begin
      num_errors++;
      $display("[ERR] %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  task automatic cyc(input int n);
    repeat (n) @(posedge clock);
  endtask
  task automatic wreg(input logic [7:0] a, d);
    @(posedge clock) wr <= 1'b1;
    addr  <= a;
    wdata <= d;
    @(posedge clock) wr <= 1'b0;
  endtask
  task automatic rreg(input logic [7:0] a, output logic [7:0] d);
    @(posedge clock) rd <= 1'b1;
    addr <= a;
    @(posedge clock) rd <= 1'b0;
    #1 d = rdata;
  endtask
  task automatic pulse_tx(input int n);
    @(posedge clock) tbw <= 1'b1;
    cyc(n - 1);
    @(posedge clock) tbw <= 1'b0;
  endtask
  task automatic fr(input logic [3:0] md, input int n, input logic [2:0] t,
                    input logic p, o, ep, input logic [7:0] eb);
    wreg(8'h71, {4'h0, md});
    hfs_far_model_inst.send(n, t, p, 1'b0, o);
    #1 check("push", {7'h0, push}, {7'h0, ep});
    check("drop", {7'h0, drop}, {7'h0, !ep});
    if (ep) check("status", bdata & 8'hf0, eb);
  endtask
  ////////////////////////////////////////////////////////////////////////////
  task automatic t_reset;
    rreg(8'h64, data);
    check("sigstat", data, 8'h48);
    rreg(8'h00, data);
    check("unmapped", data, 8'h00);
  endtask
  task automatic t_tx;
    pulse_tx(32);
    rreg(8'h64, data);
    check("ovf32", data & 8'h80, 8'h00);
    pulse_tx(1);
    rreg(8'h64, data);
    check("ovf33", data & 8'hc0, 8'h80);
    @(posedge clock) thm <= 1'b1;
    @(posedge clock) thm <= 1'b0;
    rreg(8'h64, data);
    check("moved", data & 8'hc0, 8'h40);
    pulse_tx(33);
    wreg(8'h70, 8'h01);
    rreg(8'h64, data);
    check("txres", data & 8'h80, 8'h00);
    cyc(CIP + 2);
  endtask
  task automatic t_cmd;
    wreg(8'h70, 8'h02);
    rreg(8'h64, data);
    check("busy", data & 8'h24, 8'h24);
    cyc(CIP);
    rreg(8'h64, data);
    check("done", data & 8'h24, 8'h20);
    wreg(8'h70, 8'h00);
    cyc(CIP + 2);
    rreg(8'h64, data);
    check("repclr", data & 8'h20, 8'h00);
  endtask
  task automatic t_status;
    @(posedge clock) frz <= 1'b1;
    hfs_far_model_inst.set_flag(1'b1);
    cyc(3);
    rreg(8'h64, data);
    check("frz_on", data & 8'h0a, 8'h02);
    @(posedge clock) frz <= 1'b0;
    hfs_far_model_inst.set_flag(1'b0);
    cyc(3);
    rreg(8'h64, data);
    check("frz_off", data & 8'h0a, 8'h08);
  endtask
  task automatic t_frames;
    fr(4'h3, 5, 3'h0, 1'b1, 1'b0, 1'b1, 8'ha0);
    fr(4'h3, 4, 3'h0, 1'b1, 1'b0, 1'b1, 8'h20);
    fr(4'h3, 3, 3'h0, 1'b1, 1'b0, 1'b0, 8'h00);
    fr(4'hb, 3, 3'h0, 1'b1, 1'b0, 1'b1, 8'h20);
    fr(4'hb, 2, 3'h0, 1'b1, 1'b0, 1'b0, 8'h00);
    fr(4'h2, 3, 3'h0, 1'b1, 1'b0, 1'b1, 8'h20);
    fr(4'h2, 4, 3'h0, 1'b1, 1'b0, 1'b1, 8'ha0);
    fr(4'ha, 2, 3'h0, 1'b1, 1'b0, 1'b1, 8'h20);
    fr(4'ha, 1, 3'h0, 1'b1, 1'b0, 1'b0, 8'h00);
    fr(4'h3, 5, 3'h3, 1'b1, 1'b0, 1'b1, 8'h20);
    fr(4'h3, 5, 3'h0, 1'b0, 1'b0, 1'b1, 8'h80);
    hfs_far_model_inst.send(5, 3'h0, 1'b1, 1'b1, 1'b0);
    rreg(8'h74, data);
    check("aborted", data & 8'h10, 8'h10);
  endtask
  task automatic t_irq;
    wreg(8'h73, 8'h02);
    rreg(8'h72, data);
    fr(4'h3, 5, 3'h0, 1'b1, 1'b1, 1'b1, 8'he0);
    check("irq_ovf", {7'h0, irq}, 8'h01);
    rreg(8'h72, data);
    check("ovf_stat", data & 8'h01, 8'h01);
    cyc(1);
    #1 check("irq_clr", {7'h0, irq}, 8'h00);
    wreg(8'h73, 8'h03);
    fr(4'h3, 5, 3'h0, 1'b1, 1'b0, 1'b1, 8'ha0);
    cyc(2);
    #1 check("irq_mask", {7'h0, irq}, 8'h00);
    wreg(8'h73, 8'h00);
    cyc(2);
    #1 check("irq_end", {7'h0, irq}, 8'h01);
  endtask
  task automatic summarize;
    $display("errors %0d comparisons %0d", num_errors, cmp_count);
    if (num_errors == 0 && cmp_count > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask
  always @(posedge clock) begin
    cycles++;
    if (cycles == 20000) begin
      num_errors++;
      summarize();
    end
  end
  initial begin
    cyc(2);
    rst <= 1'b0;
    t_reset();
    t_tx();
    t_cmd();
    t_status();
    t_frames();
    t_irq();
    summarize();
  end
endmodule // hfs_frame_status_tb_top
`default_nettype wire
